// ### rtl/sram_cfg.svh
`ifndef SRAM_CFG_SVH
`define SRAM_CFG_SVH
`define SRAM_ADDR_W 14
`define SRAM_DATA_W 4
`define SRAM_DEPTH 16384
`define SRAM_ADDR_ZERO 14'h0000
`define SRAM_DATA_ZERO 4'h0
`endif

// ### rtl/sram_pkg.sv
`include "sram_cfg.svh"
package sram_pkg;
  typedef logic [`SRAM_ADDR_W-1:0] addr_t;
  typedef logic [`SRAM_DATA_W-1:0] data_t;
  typedef enum logic [2:0] {
    CTL_IDLE = 3'h1,
    CTL_WRITE = 3'h2,
    CTL_READ = 3'h4
  } ctl_state_t;
endpackage : sram_pkg

// ### rtl/sram_link_if.sv
`timescale 1ns/10ps
interface sram_link_if;
  logic mem_clock;
  sram_pkg::addr_t addr_in;
  sram_pkg::data_t din;
  logic write_strobe_n;
  logic output_enable_n;
  sram_pkg::data_t dout;
  logic dout_oe;
  modport device (input mem_clock, input addr_in, input din, input write_strobe_n,
    input output_enable_n, output dout, output dout_oe);
  modport host (output mem_clock, output addr_in, output din, output write_strobe_n,
    output output_enable_n, input dout, input dout_oe);
endinterface : sram_link_if

// ### rtl/sync_sram_transparent_out.sv
`timescale 1ns/10ps
`include "sram_cfg.svh"
module sync_sram_transparent_out (
  // System
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Link
  sram_link_if.device link
);
  import sram_pkg::*;

  typedef struct packed {
    logic clk_d;
    addr_t addr;
    data_t wdata;
    logic wr;
    logic wr_prev;
    logic valid;
    data_t dout;
    logic dout_oe;
  } dev_state_t;

  dev_state_t st_r;
  dev_state_t st_nxt;
  data_t mem_r [`SRAM_DEPTH];
  logic rise;
  logic fall;
  logic wr_go;
  data_t rd_word;

  // The pin clock is sampled by clk_sys; it must run at half of clk_sys or slower.
  assign rise = link.mem_clock & ~st_r.clk_d;
  assign fall = ~link.mem_clock & st_r.clk_d;
  assign wr_go = rise & ~link.write_strobe_n;
  // Array write lands in the edge cycle, so later reads see it
  assign rd_word = mem_r[st_r.addr];

  always_comb begin
    st_nxt = st_r;
    st_nxt.clk_d = link.mem_clock;
    if (rise) begin
      st_nxt.addr = link.addr_in;
      st_nxt.wdata = link.din;
      st_nxt.wr_prev = st_r.wr;
      st_nxt.wr = ~link.write_strobe_n;
      st_nxt.valid = 1'b1;
    end
    // Data only moves in the low phase; high phase holds it
    if (~link.mem_clock & ~st_nxt.clk_d & st_r.valid) begin
      if (st_r.wr) begin
        st_nxt.dout_oe = 1'b0;
      end else begin
        st_nxt.dout = rd_word;
        st_nxt.dout_oe = ~link.output_enable_n;
      end
    end
    // Disable acts without waiting for a clock phase; enable waits for the low phase
    if (link.output_enable_n & ~(st_r.wr & st_r.wr_prev)) begin
      st_nxt.dout_oe = 1'b0;
    end
    if (st_r.wr & st_r.wr_prev) begin
      st_nxt.dout_oe = 1'b0;
    end
    if (fall & st_r.valid & ~st_r.wr) begin
      st_nxt.dout = rd_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Storage has no reset, as in a real array
  always_ff @(posedge clk_sys) begin
    if (clk_en & wr_go & ~srst) begin
      mem_r[link.addr_in] <= link.din;
    end
  end

  assign link.dout = st_r.dout;
  assign link.dout_oe = st_r.dout_oe;
endmodule : sync_sram_transparent_out

// ### rtl/sram_bus_ctrl.sv
`timescale 1ns/10ps
`include "sram_cfg.svh"
module sram_bus_ctrl (
  // System
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  // Request
  input wire logic req_valid,
  input wire logic req_write,
  input wire sram_pkg::addr_t req_addr,
  input wire sram_pkg::data_t req_wdata,
  output logic req_ready,
  // Answer
  output logic rsp_valid,
  output sram_pkg::data_t rsp_rdata,
  // Output enable level
  input wire logic oe_req_n,
  // Link
  sram_link_if.host link
);
  import sram_pkg::*;

  typedef struct packed {
    ctl_state_t state;
    logic clk;
    addr_t addr;
    data_t wdata;
    logic wr_n;
    logic oe_n;
    logic ready;
    logic rsp;
    data_t rdata;
    logic seen;
  } ctl_t;

  ctl_t st_r;
  ctl_t st_nxt;

  // Memory clock is clk_sys divided by two and runs free; address, data and strobe change as it
  // falls, which gives a full clk_sys of setup before the rise.
  always_comb begin
    st_nxt = st_r;
    st_nxt.clk = ~st_r.clk;
    st_nxt.rsp = 1'b0;
    st_nxt.oe_n = oe_req_n;
    unique case (st_r.state)
      CTL_IDLE: begin
        st_nxt.ready = 1'b1;
        st_nxt.wr_n = 1'b1;
        st_nxt.seen = 1'b0;
      end
      CTL_WRITE: begin
        // Ready opens early so a following write rides the capturing rise
        if (~st_r.clk) begin
          st_nxt.ready = 1'b1;
        end else begin
          st_nxt.wr_n = 1'b1;
          st_nxt.state = CTL_IDLE;
        end
      end
      CTL_READ: begin
        // First rise captures the access, the next one samples the low-phase data
        if (st_r.clk) begin
          st_nxt.seen = 1'b1;
          if (st_r.seen) begin
            st_nxt.state = CTL_IDLE;
            st_nxt.ready = 1'b1;
            st_nxt.seen = 1'b0;
            if (link.dout_oe) begin
              st_nxt.rsp = 1'b1;
              st_nxt.rdata = link.dout;
            end
          end
        end
      end
      default: st_nxt.state = CTL_IDLE;
    endcase
    if (st_r.clk & st_r.ready & req_valid) begin
      st_nxt.addr = req_addr;
      st_nxt.wdata = req_wdata;
      st_nxt.wr_n = ~req_write;
      st_nxt.ready = 1'b0;
      st_nxt.seen = 1'b0;
      st_nxt.state = req_write ? CTL_WRITE : CTL_READ;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '{state: CTL_IDLE, clk: 1'b0, addr: `SRAM_ADDR_ZERO, wdata: `SRAM_DATA_ZERO,
                wr_n: 1'b1, oe_n: 1'b1, ready: 1'b0, rsp: 1'b0, rdata: `SRAM_DATA_ZERO, seen: 1'b0};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign req_ready = st_r.ready;
  assign rsp_valid = st_r.rsp;
  assign rsp_rdata = st_r.rdata;
  assign link.mem_clock = st_r.clk;
  assign link.addr_in = st_r.addr;
  assign link.din = st_r.wdata;
  assign link.write_strobe_n = st_r.wr_n;
  assign link.output_enable_n = st_r.oe_n;
endmodule : sram_bus_ctrl

// ### dv/sram_link_sva.sv
`timescale 1ns/10ps
module sram_link_sva (
  // System
  input logic clk_sys,
  input logic srst,
  input logic clk_en,
  // Link
  input logic mem_clock,
  input logic write_strobe_n,
  input logic output_enable_n,
  input sram_pkg::data_t dout,
  input logic dout_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst || !clk_en);
  property p_off; output_enable_n |=> !dout_oe; endproperty
  a_off: assert property (p_off) else $error("oe");
  property p_hz; output_enable_n[*2] |-> !dout_oe; endproperty
  a_hz: assert property (p_hz) else $error("hz");
  property p_on; $rose(dout_oe) |-> !$past(output_enable_n); endproperty
  a_on: assert property (p_on) else $error("on");
  property p_low; $changed(dout) |-> !$past(mem_clock); endproperty
  a_low: assert property (p_low) else $error("lo");
  property p_frz; $rose(mem_clock) |=> $stable(dout); endproperty
  a_frz: assert property (p_frz) else $error("fz");
  property p_wz; $rose(mem_clock) && !write_strobe_n |-> ##[1:4] !dout_oe; endproperty
  a_wz: assert property (p_wz) else $error("wz");
  property p_rd; $rose(mem_clock) && write_strobe_n |-> ##[1:4] (dout_oe || output_enable_n); endproperty
  a_rd: assert property (p_rd) else $error("rd");
  property p_stb; $rose(mem_clock) |-> $stable(write_strobe_n); endproperty
  a_stb: assert property (p_stb) else $error("st");
  c_rd: cover property ($rose(dout_oe));
  c_wr: cover property ($fell(write_strobe_n));
  c_oe: cover property ($rose(output_enable_n));
endmodule : sram_link_sva

// ### dv/sync_sram_transparent_out_tb_top.sv
`timescale 1ns/10ps
module sync_sram_transparent_out_tb_top;
  import sram_pkg::*;
  logic clk_sys = 1'h0, srst = 1'h1, clk_en = 1'h1, req_valid = 1'h0, req_write = 1'h0, oe_req_n = 1'h0;
  logic req_ready, rsp_valid, m;
  addr_t req_addr = 14'h0000;
  data_t req_wdata = 4'h0, rsp_rdata, q;
  int bad_count = 0, checks_done = 0;
  // Write, address, data
  logic [18:0] rows [6] = '{19'h4000A, 19'h7FFF5, 19'h0000A, 19'h3FFF5, 19'h7FFFC, 19'h3FFFC};
  sram_link_if link ();
  always #25 clk_sys = ~clk_sys;
  sync_sram_transparent_out sync_sram_transparent_out_i (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
    .link(link));
  sram_bus_ctrl sram_bus_ctrl_i (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .oe_req_n(oe_req_n), .link(link));
  sram_link_sva sram_link_sva_i (.clk_sys, .srst, .clk_en, .mem_clock(link.mem_clock), .dout(link.dout),
    .write_strobe_n(link.write_strobe_n), .output_enable_n(link.output_enable_n), .dout_oe(link.dout_oe));
  task automatic chk(input data_t got, input data_t exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic end_sim;
    $display("%0d checks, %0d bad", checks_done, bad_count);
    if (!bad_count && checks_done)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Checked at the falling edge, where nothing moves until the next rise
  // Request is taken at the rise where ready and the memory clock are both high
  task automatic issue(input logic [18:0] r);
    int n = 0;
    {req_write, req_addr, req_wdata} = r;
    req_valid = 1'h1;
    while ({req_ready, link.mem_clock} !== 2'h3 && n++ < 40) @(negedge clk_sys);
    if (n > 40) begin
      bad_count++;
      end_sim();
    end
    @(negedge clk_sys);
  endtask : issue
  task automatic acc(input logic [18:0] r);
    q = 4'h0;
    issue(r);
    req_valid = 1'h0;
    repeat (10) begin
      @(negedge clk_sys);
      if (rsp_valid === 1'h1) q = rsp_rdata;
    end
  endtask : acc
  initial begin
    repeat (4) @(negedge clk_sys);
    srst = 1'h0;
    foreach (rows[i]) begin
      acc(rows[i]);
      chk(q, rows[i][18] ? 4'h0 : rows[i][3:0]);
      $display("row %0d", i);
    end
    oe_req_n = 1'h1;
    acc(rows[2]);
    chk(q, 4'h0);
    $display("oe off");
    oe_req_n = 1'h0;
    issue(19'h40015);
    issue(19'h40026);
    req_valid = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk_bit(link.dout_oe, 1'h0);
    acc(19'h00010);
    chk(q, 4'h5);
    acc(19'h00020);
    chk(q, 4'h6);
    $display("back to back writes");
    srst = 1'h1;
    @(negedge clk_sys);
    chk_bit(link.dout_oe, 1'h0);
    chk_bit(req_ready, 1'h0);
    @(negedge clk_sys);
    srst = 1'h0;
    acc(19'h00020);
    chk(q, 4'h6);
    $display("mid-run reset");
    m = link.mem_clock;
    clk_en = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk_bit(link.mem_clock, m);
    clk_en = 1'h1;
    acc(19'h00010);
    chk(q, 4'h5);
    $display("clock enable");
    end_sim();
  end
endmodule : sync_sram_transparent_out_tb_top
